/* rtl/epd_map.vh */
// register map, field positions, reset values and timing counts for the encoder pulse output divider
// Behaviour
// [R1] emit A/B/Z as differential line-driver pairs
// [R2] scale output count by numerator over denominator
// [R3] one setting picks AB logic and source
// [R4] scale source: Z at configured interval
// [R5] quadrature edge rate at most 4 Mpps
// [R6] resolution multiple of four: Z follows A
// [R7] otherwise Z one encoder step wide
// [R8] host waits for first Z before trusting
// [R9] Z also on open-collector output
// [R10] torque sel 0,11,12: signed torque command
// [R11] torque sel 1-5: signed positional deviation
// [R12] torque sel 6-10: signed full-closed deviation
// [R13] torque sel also sets output scaling
// [R14] speed sel 0-4: signed motor speed
// [R15] speed sel 5-9: signed command speed
// [R16] A/B quarter period apart, direction-led
`ifndef EPD_MAP_VH
`define EPD_MAP_VH
// axi-lite byte offsets
`define EPD_OFF_NUM 8'h00
`define EPD_OFF_DEN 8'h04
`define EPD_OFF_SEL 8'h08
`define EPD_OFF_ZINT 8'h0C
`define EPD_OFF_TSEL 8'h10
`define EPD_OFF_SSEL 8'h14
`define EPD_OFF_STAT 8'h18
// field positions
`define EPD_SEL_REV 0
`define EPD_SEL_SCALE 1
`define EPD_STAT_ZSEEN 0
`define EPD_STAT_ALIGN 1
`define EPD_STAT_BUSY 2
// reset values
`define EPD_RST_NUM 24'h00_0001
`define EPD_RST_DEN 16'h0001
`define EPD_RST_SEL 2'b00
`define EPD_RST_ZINT 16'h0001
`define EPD_RST_MSEL 4'h0
// axi responses
`define EPD_RESP_OKAY 2'b00
`define EPD_RESP_SLVERR 2'b10
// timing: 4 Mpps edge limit at 250 MHz, least spacing rounded up
`define EPD_CLK_KHZ 250000
`define EPD_MAX_EDGE_KPPS 4000
`define EPD_EDGE_CYC ((`EPD_CLK_KHZ + `EPD_MAX_EDGE_KPPS - 1) / `EPD_MAX_EDGE_KPPS)
`endif

/* rtl/epd_top.v */
// encoder pulse output divider with monitor selection and axi-lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "epd_map.vh"
module epd_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi-lite write address / data / response
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // position sources, one-cycle step pulses
  input wire enc_step,
  input wire enc_dir_ccw,
  input wire enc_z,
  input wire scale_step,
  input wire scale_dir_ccw,
  // monitored quantities, signed
  input wire [31:0] torque_cmd,
  input wire [31:0] pos_deviation,
  input wire [31:0] fc_deviation,
  input wire [31:0] motor_speed,
  input wire [31:0] cmd_speed,
  // pulse outputs
  output reg a_phase_out_pos,
  output reg a_phase_out_neg,
  output reg b_phase_out_pos,
  output reg b_phase_out_neg,
  output reg z_phase_out_pos,
  output reg z_phase_out_neg,
  output wire z_phase_open_collector_o,
  output reg z_phase_open_collector_oe,
  // monitor outputs
  output reg [15:0] torque_monitor_out,
  output reg [15:0] speed_monitor_out
);

  localparam integer EDGE_CYC_I = `EPD_EDGE_CYC;
  localparam [6:0] EDGE_CYC = EDGE_CYC_I[6:0];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // arithmetic shift right then saturate to 16 bits
  function [15:0] scale_sat;
    input [31:0] val;
    input [2:0] sh;
    reg signed [31:0] s;
    begin
      s = $signed(val) >>> sh;
      if (s > 32'sd32767)
        scale_sat = 16'h7FFF;
      else if (s < -32'sd32768)
        scale_sat = 16'h8000;
      else
        scale_sat = s[15:0];
    end
  endfunction

  // merge write strobes into a word
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          wmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [23:0] num_q;
  reg [15:0] den_q;
  reg [1:0] sel_q;
  reg [15:0] zint_q;
  reg [3:0] tsel_q;
  reg [3:0] ssel_q;
  reg z_seen_q;
  reg align_q;
  reg busy_q;
  reg cfg_chg;

  // write channel: address and data taken independently
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write;
  // strobe-merged write words, cut back to each register's width below
  wire [31:0] num_wr = wmerge({8'h00, num_q}, w_data_q, w_strb_q);
  wire [31:0] den_wr = wmerge({16'h0000, den_q}, w_data_q, w_strb_q);
  wire [31:0] zint_wr = wmerge({16'h0000, zint_q}, w_data_q, w_strb_q);

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EPD_RESP_OKAY;
      num_q <= `EPD_RST_NUM;
      den_q <= `EPD_RST_DEN;
      sel_q <= `EPD_RST_SEL;
      zint_q <= `EPD_RST_ZINT;
      tsel_q <= `EPD_RST_MSEL;
      ssel_q <= `EPD_RST_MSEL;
      cfg_chg <= 1'b1;
    end else begin
      cfg_chg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `EPD_RESP_OKAY;
        case (aw_addr_q)
          `EPD_OFF_NUM: begin
            num_q <= num_wr[23:0]; // see [R2]
            cfg_chg <= 1'b1;
          end
          `EPD_OFF_DEN: begin
            den_q <= den_wr[15:0]; // see [R2]
            cfg_chg <= 1'b1;
          end
          `EPD_OFF_SEL: sel_q <= w_strb_q[0] ? w_data_q[1:0] : sel_q; // see [R3]
          `EPD_OFF_ZINT: zint_q <= zint_wr[15:0]; // see [R4]
          `EPD_OFF_TSEL: tsel_q <= w_strb_q[0] ? w_data_q[3:0] : tsel_q;
          `EPD_OFF_SSEL: ssel_q <= w_strb_q[0] ? w_data_q[3:0] : ssel_q;
          `EPD_OFF_STAT: s_axi_bresp <= `EPD_RESP_OKAY;
          default: s_axi_bresp <= `EPD_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EPD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EPD_RESP_OKAY;
      case (s_axi_araddr)
        `EPD_OFF_NUM: s_axi_rdata <= {8'h00, num_q};
        `EPD_OFF_DEN: s_axi_rdata <= {16'h0000, den_q};
        `EPD_OFF_SEL: s_axi_rdata <= {30'h0, sel_q};
        `EPD_OFF_ZINT: s_axi_rdata <= {16'h0000, zint_q};
        `EPD_OFF_TSEL: s_axi_rdata <= {28'h000_0000, tsel_q};
        `EPD_OFF_SSEL: s_axi_rdata <= {28'h000_0000, ssel_q};
        `EPD_OFF_STAT: s_axi_rdata <= {29'h0, busy_q, align_q, z_seen_q}; // see [R8]
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `EPD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resolution check: serial division of numerator by denominator

  reg [4:0] div_cnt_q;
  reg [23:0] div_quo_q;
  reg [16:0] div_rem_q;
  wire [16:0] div_try = {div_rem_q[15:0], div_quo_q[23]};

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 5'd0;
      div_quo_q <= 24'h00_0000;
      div_rem_q <= 17'h0_0000;
      busy_q <= 1'b0;
      align_q <= 1'b0;
    end else if (cfg_chg) begin
      div_cnt_q <= 5'd24;
      div_quo_q <= num_q;
      div_rem_q <= 17'h0_0000;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (div_try >= {1'b0, den_q}) begin
        div_rem_q <= div_try - {1'b0, den_q};
        div_quo_q <= {div_quo_q[22:0], 1'b1};
      end else begin
        div_rem_q <= div_try;
        div_quo_q <= {div_quo_q[22:0], 1'b0};
      end
      div_cnt_q <= div_cnt_q - 5'd1;
      if (div_cnt_q == 5'd1)
        busy_q <= 1'b0;
    end else begin
      // exact ratio whose quotient is a multiple of four
      align_q <= (div_rem_q == 17'h0_0000) && (div_quo_q[1:0] == 2'b00) && (den_q != 16'h0000); // see [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratio accumulator and pending edge count

  wire use_scale = sel_q[`EPD_SEL_SCALE];
  wire src_step = use_scale ? scale_step : enc_step; // see [R3]
  wire src_ccw = use_scale ? scale_dir_ccw : enc_dir_ccw;
  reg signed [25:0] acc_q;
  reg signed [15:0] pend_q;
  reg [6:0] rate_q;
  reg [1:0] ph_q;
  wire edge_ok = (rate_q == 7'd0) && (pend_q != 16'sd0);
  wire edge_up = !pend_q[15];
  wire [1:0] ph_nx = edge_up ? ph_q + 2'd1 : ph_q - 2'd1;
  // pending change from an emitted edge: an up edge drains a positive count, a down edge a negative one
  wire signed [15:0] pend_out = edge_ok ? (edge_up ? -16'sd1 : 16'sd1) : 16'sd0;

  // one division step per cycle: source steps must be slower than the clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 26'sd0;
      pend_q <= 16'sd0;
    end else begin
      if (src_step) begin
        if (src_ccw)
          acc_q <= acc_q + $signed({2'b00, num_q}); // see [R2]
        else
          acc_q <= acc_q - $signed({2'b00, num_q});
        pend_q <= pend_q + pend_out;
      end else if (den_q != 16'h0000 && acc_q >= $signed({10'h000, den_q})) begin
        acc_q <= acc_q - $signed({10'h000, den_q});
        pend_q <= pend_q + 16'sd1 + pend_out;
      end else if (den_q != 16'h0000 && acc_q < 26'sd0) begin
        acc_q <= acc_q + $signed({10'h000, den_q});
        pend_q <= pend_q - 16'sd1 + pend_out;
      end else begin
        pend_q <= pend_q + pend_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate-limited quadrature generator

  always @(posedge aclk) begin
    if (!aresetn) begin
      rate_q <= 7'd0;
      ph_q <= 2'b00;
    end else if (edge_ok) begin
      rate_q <= EDGE_CYC - 7'd1; // see [R5]
      ph_q <= ph_nx; // see [R16]
    end else if (rate_q != 7'd0) begin
      rate_q <= rate_q - 7'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // z generation

  reg z_arm_q;
  reg z_q;
  reg [15:0] zcnt_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      z_arm_q <= 1'b0;
      z_q <= 1'b0;
      zcnt_q <= 16'h0000;
      z_seen_q <= 1'b0;
    end else if (use_scale) begin
      z_arm_q <= 1'b0;
      if (edge_ok) begin
        // z lasts one output edge once per interval
        if (zcnt_q + 16'h0001 >= zint_q) begin
          zcnt_q <= 16'h0000;
          z_q <= 1'b1; // see [R4]
        end else begin
          zcnt_q <= zcnt_q + 16'h0001;
          z_q <= 1'b0;
        end
      end
    end else if (align_q) begin
      if (enc_z)
        z_arm_q <= 1'b1;
      if (edge_ok) begin
        if (z_arm_q && ph_nx == 2'b10) begin
          z_q <= 1'b1; // see [R6]
          z_arm_q <= enc_z;
        end else if (z_q) begin
          z_q <= 1'b0;
        end
      end
    end else begin
      z_arm_q <= 1'b0;
      if (enc_z)
        z_q <= 1'b1; // see [R7]
      else if (enc_step)
        z_q <= 1'b0;
    end
    // reset wins: status is sticky until reset
    if (aresetn && z_q)
      z_seen_q <= 1'b1; // see [R8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  wire a_lvl = ph_q[1];
  wire b_lvl = ph_q[1] ^ ph_q[0];
  wire b_out = b_lvl ^ sel_q[`EPD_SEL_REV]; // see [R3]

  assign z_phase_open_collector_o = 1'b0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      a_phase_out_pos <= 1'b0;
      a_phase_out_neg <= 1'b1;
      b_phase_out_pos <= 1'b0;
      b_phase_out_neg <= 1'b1;
      z_phase_out_pos <= 1'b0;
      z_phase_out_neg <= 1'b1;
      z_phase_open_collector_oe <= 1'b0;
    end else begin
      a_phase_out_pos <= a_lvl; // see [R1]
      a_phase_out_neg <= ~a_lvl;
      b_phase_out_pos <= b_out;
      b_phase_out_neg <= ~b_out;
      z_phase_out_pos <= z_q;
      z_phase_out_neg <= ~z_q;
      z_phase_open_collector_oe <= z_q; // see [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog monitor selection, coarser scale at higher select values within each source

  always @(posedge aclk) begin
    if (!aresetn) begin
      torque_monitor_out <= 16'h0000;
      speed_monitor_out <= 16'h0000;
    end else begin
      case (tsel_q)
        4'd0: torque_monitor_out <= scale_sat(torque_cmd, 3'd0); // see [R10]
        4'd11: torque_monitor_out <= scale_sat(torque_cmd, 3'd1); // see [R13]
        4'd12: torque_monitor_out <= scale_sat(torque_cmd, 3'd2);
        4'd1, 4'd2, 4'd3, 4'd4, 4'd5:
          torque_monitor_out <= scale_sat(pos_deviation, tsel_q[2:0] - 3'd1); // see [R11] [R13]
        4'd6, 4'd7, 4'd8, 4'd9, 4'd10:
          torque_monitor_out <= scale_sat(fc_deviation, tsel_q[2:0] - 3'd6); // see [R12] [R13]
        default: torque_monitor_out <= 16'h0000;
      endcase
      case (ssel_q)
        4'd0, 4'd1, 4'd2, 4'd3, 4'd4:
          speed_monitor_out <= scale_sat(motor_speed, ssel_q[2:0]); // see [R14]
        4'd5, 4'd6, 4'd7, 4'd8, 4'd9:
          speed_monitor_out <= scale_sat(cmd_speed, ssel_q[2:0] - 3'd5); // see [R15]
        default: speed_monitor_out <= 16'h0000;
      endcase
    end
  end

endmodule

/* tb/epd_host_model.sv */
// host-side quadrature counter watching the divided pulse outputs
`timescale 1ns/1ps
module epd_host_model (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pulse pins
  input wire a_phase_out_pos,
  input wire a_phase_out_neg,
  input wire b_phase_out_pos,
  input wire z_phase_out_pos,
  // counts
  output reg signed [31:0] pos_cnt_q,
  output reg [31:0] z_cnt_q,
  output reg z_seen_q,
  output reg pair_err_q
);
  // gray index: up order is 00,01,11,10
  reg [1:0] idx_q;
  reg z_q;
  wire [1:0] idx = {a_phase_out_pos, a_phase_out_pos ^ b_phase_out_pos};
  wire [1:0] dlt = idx - idx_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      idx_q <= 2'b00;
      z_q <= 1'b0;
      pos_cnt_q <= 0;
      z_cnt_q <= 0;
      z_seen_q <= 1'b0;
      pair_err_q <= 1'b0;
    end else begin
      idx_q <= idx;
      z_q <= z_phase_out_pos;
      if (dlt == 2'd1) pos_cnt_q <= pos_cnt_q + 1;
      if (dlt == 2'd3) pos_cnt_q <= pos_cnt_q - 1;
      // a skipped state means lost position, so it is flagged
      if (dlt == 2'd2 || a_phase_out_neg == a_phase_out_pos) pair_err_q <= 1'b1;
      if (z_phase_out_pos && !z_q) begin
        z_cnt_q <= z_cnt_q + 1;
        z_seen_q <= 1'b1;
      end
    end
  end
endmodule

/* tb/epd_monitor.sv */
// assertion checker on the ports of the encoder pulse output divider
`timescale 1ns/1ps
module epd_monitor (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi-lite handshakes
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // pulse pins
  input wire a_phase_out_pos,
  input wire a_phase_out_neg,
  input wire b_phase_out_pos,
  input wire b_phase_out_neg,
  input wire z_phase_out_pos,
  input wire z_phase_out_neg,
  input wire z_phase_open_collector_o,
  input wire z_phase_open_collector_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // cycles since the last a/b edge, saturating so reset looks idle
  reg a_q;
  reg b_q;
  reg [5:0] gap_q;
  wire ab_edge = (a_phase_out_pos ^ a_q) | (b_phase_out_pos ^ b_q);
  always @(posedge aclk) begin
    if (!aresetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      gap_q <= 6'h3F;
    end else begin
      a_q <= a_phase_out_pos;
      b_q <= b_phase_out_pos;
      gap_q <= ab_edge ? 6'h00 : (gap_q == 6'h3F ? gap_q : gap_q + 6'h01);
    end
  end
  ////////////////////////////////////////////////////////////////
  a_diff_pairs: assert property (a_phase_out_neg == !a_phase_out_pos && b_phase_out_neg == !b_phase_out_pos
    && z_phase_out_neg == !z_phase_out_pos) else $error("line pair not complementary");
  a_oc_z_copy: assert property (z_phase_open_collector_oe == z_phase_out_pos
    && !z_phase_open_collector_o) else $error("open collector z differs");
  a_edge_spacing: assert property (ab_edge |-> gap_q >= 6'd62) else $error("quadrature edges too close");
  a_quarter_step: assert property (!($changed(a_phase_out_pos) && $changed(b_phase_out_pos)))
    else $error("a and b moved together");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule
bind epd_top epd_monitor i_epd_monitor (.*);

/* tb/epd_top_tb_top.sv */
// self-checking bench for the encoder pulse output divider
`timescale 1ns/1ps
`include "epd_map.vh"
module epd_top_tb_top;
  reg aclk = 0;
  reg aresetn = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0, d, base, e;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg enc_step = 0, enc_dir_ccw = 0, enc_z = 0, scale_step = 0, scale_dir_ccw = 0;
  reg [31:0] torque_cmd = 32'h0001_86A0, pos_deviation = 32'h0000_0960, fc_deviation = 32'hFFFF_FCE0;
  reg [31:0] motor_speed = 32'hFFFF_FD80, cmd_speed = 32'h0000_0140;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, z_cnt_q;
  wire a_phase_out_pos, a_phase_out_neg, b_phase_out_pos, b_phase_out_neg, z_phase_out_pos, z_phase_out_neg;
  wire z_phase_open_collector_o, z_phase_open_collector_oe, z_seen_q, pair_err_q;
  wire [15:0] torque_monitor_out, speed_monitor_out;
  wire signed [31:0] pos_cnt_q;
  int err_count = 0, tests_run = 0;
  // rows: numerator, denominator, select, scale source, ccw, steps, expected count change
  int t[6][7] = '{'{4, 1, 0, 0, 1, 3, 12}, '{4, 1, 0, 0, 0, 3, -12}, '{4, 1, 1, 0, 1, 2, -8},
    '{1, 2, 0, 0, 1, 4, 2}, '{1, 2, 2, 0, 1, 2, 0}, '{1, 2, 2, 1, 1, 2, 1}};
  always #2 aclk = ~aclk;
  epd_top i_epd_top (.*);
  epd_host_model i_epd_host_model (.*);
  ////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    @(posedge aclk);
    while (!s_axi_bvalid && n < 100) begin
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n++;
      @(posedge aclk);
    end
    s_axi_bready <= 0;
    chk(s_axi_bvalid, 1);
    chk(s_axi_bresp, er);
    // let an edge pass so the next call does not re-raise bready in this step
    @(posedge aclk);
  endtask
  task rd(input [7:0] a, output [31:0] v, input [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    @(posedge aclk);
    while (!s_axi_rvalid && n < 100) begin
      if (s_axi_arready) s_axi_arvalid <= 0;
      n++;
      @(posedge aclk);
    end
    s_axi_rready <= 0;
    v = s_axi_rdata;
    chk(s_axi_rvalid, 1);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask
  // steps are spaced so the paced output edges of one step finish first
  task stp(input bit s, input bit ccw, input int n);
    repeat (n) begin
      enc_dir_ccw <= ccw;
      scale_dir_ccw <= ccw;
      if (s) scale_step <= 1;
      else enc_step <= 1;
      @(posedge aclk);
      enc_step <= 0;
      scale_step <= 0;
      repeat (300) @(posedge aclk);
    end
  endtask
  function automatic [15:0] sat(input [31:0] v, input int sh);
    reg signed [31:0] r;
    r = $signed(v) >>> sh;
    if (r > 32767) return 16'h7FFF;
    if (r < -32768) return 16'h8000;
    return r[15:0];
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d, `EPD_RESP_OKAY);
      chk(d, (i == 2 || i > 3) ? 0 : 1);
    end
    rd(8'h1C, d, `EPD_RESP_SLVERR);
    chk(d, 0);
    wr(8'h20, 32'h0000_0005, `EPD_RESP_SLVERR);
    wr(`EPD_OFF_STAT, 32'hFFFF_FFFF, `EPD_RESP_OKAY);
    wr(`EPD_OFF_NUM, 32'hFFFF_FFFF, `EPD_RESP_OKAY);
    rd(`EPD_OFF_NUM, d, `EPD_RESP_OKAY);
    chk(d, 32'h00FF_FFFF);
    s_axi_wstrb <= 4'h1;
    wr(`EPD_OFF_NUM, 32'h0000_0012, `EPD_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`EPD_OFF_NUM, d, `EPD_RESP_OKAY);
    chk(d, 32'h00FF_FF12);
    foreach (t[i]) begin
      wr(`EPD_OFF_NUM, t[i][0], `EPD_RESP_OKAY);
      wr(`EPD_OFF_DEN, t[i][1], `EPD_RESP_OKAY);
      wr(`EPD_OFF_SEL, t[i][2], `EPD_RESP_OKAY);
      // a logic flip moves b; wait out the edge spacing before the next output edge
      repeat (70) @(posedge aclk);
      base = pos_cnt_q;
      stp(t[i][3][0], t[i][4][0], t[i][5]);
      chk(pos_cnt_q - base, t[i][6]);
    end
    for (int k = 0; k < 2; k++) begin
      wr(`EPD_OFF_NUM, k ? 1 : 4, `EPD_RESP_OKAY);
      wr(`EPD_OFF_DEN, k ? 2 : 1, `EPD_RESP_OKAY);
      wr(`EPD_OFF_SEL, 0, `EPD_RESP_OKAY);
      repeat (30) @(posedge aclk);
      rd(`EPD_OFF_STAT, d, `EPD_RESP_OKAY);
      chk(d & 2, k ? 0 : 2);
      base = z_cnt_q;
      enc_z <= 1;
      @(posedge aclk);
      enc_z <= 0;
      stp(0, 1, 2);
      chk(z_cnt_q - base, 1);
      chk(z_seen_q, 1);
    end
    rd(`EPD_OFF_STAT, d, `EPD_RESP_OKAY);
    chk(d & 1, 1);
    for (int s = 0; s < 13; s++) begin
      wr(`EPD_OFF_TSEL, s, `EPD_RESP_OKAY);
      wr(`EPD_OFF_SSEL, s, `EPD_RESP_OKAY);
      repeat (4) @(posedge aclk);
      if (s == 0 || s > 10) e = sat(torque_cmd, s ? s - 10 : 0);
      else if (s < 6) e = sat(pos_deviation, s - 1);
      else e = sat(fc_deviation, s - 6);
      chk(torque_monitor_out, e);
      e = s < 5 ? sat(motor_speed, s) : s < 10 ? sat(cmd_speed, s - 5) : 0;
      chk(speed_monitor_out, e);
    end
    chk(pair_err_q, 0);
    finish_test;
  end
endmodule
